// File: common/timer3_ccp_defs.vh
/*
 * register offsets, field positions, reset values, mode codes and the timing
 * constants of the 16-bit time base and the capture/compare/pwm mode control.
 * assumes a byte-wide register port with a 4-bit address.
 */
`ifndef TIMER3_CCP_DEFS_VH
`define TIMER3_CCP_DEFS_VH

// register offsets (byte port, one register per address)
`define OFS_TIMER_COUNT_LOW   4'h0
`define OFS_TIMER_COUNT_HIGH  4'h1
`define OFS_TIMER_CONTROL     4'h2
`define OFS_UNIT_CONTROL      4'h3
`define OFS_UNIT_DATA_LOW     4'h4
`define OFS_UNIT_DATA_HIGH    4'h5
`define OFS_AUX_CONTROL       4'h6
`define OFS_EVENT_STATUS      4'h7

// timer_control fields
`define TC_WIDE_ACCESS        7
`define TC_UNIT3_SELECT       6
`define TC_PRESCALE_HI        5
`define TC_PRESCALE_LO        4
`define TC_UNIT1_SELECT       3
`define TC_NO_SYNC            2
`define TC_EXT_CLOCK_SELECT   1
`define TC_TIMER_ON           0

// unit_control fields
`define UC_DUTY_HI            5
`define UC_DUTY_LO            4
`define UC_MODE_HI            3
`define UC_MODE_LO            0
`define UC_WRITE_MASK         8'h3f

// aux_control fields
`define AUX_LOW_FREQ_OSC_EN   0
`define AUX_OVERFLOW_IRQ_EN   1
`define AUX_CAN_STAMP_SELECT  2
`define AUX_ADC_ENABLE        3

// event_status fields, write one to clear
`define ST_OVERFLOW_FLAG      0
`define ST_UNIT_EVENT_FLAG    1

// reset values and the timer's top count
`define RST_BYTE              8'h00
`define RST_WORD              16'h0000
`define TIMER_MAX             16'hffff

// unit mode codes
`define MODE_OFF              4'h0
`define MODE_CMP_TOGGLE       4'h2
`define MODE_CAP_FALL         4'h4
`define MODE_CAP_RISE         4'h5
`define MODE_CAP_RISE4        4'h6
`define MODE_CAP_RISE16       4'h7
`define MODE_CMP_SET_HIGH     4'h8
`define MODE_CMP_SET_LOW      4'h9
`define MODE_CMP_SOFT         4'ha
`define MODE_CMP_SPECIAL      4'hb

// instruction clock is the system clock divided by four
`define INSTR_CLOCK_DIV       4
`define INSTR_DIV_LAST        2'h3

`endif

// File: src/timer3_ccp_mode_control.v
/*
 * 16-bit time base with prescaler, overflow flag and special-event reset,
 * together with the mode control of one capture/compare/pwm unit: capture
 * edge selection, compare pin actions, special-event trigger and pwm duty.
 * assumes one 250 MHz system clock, a byte register port answered one cycle
 * after the read strobe, and that the external clock and capture pins are
 * asynchronous while the can receive pulse is on the system clock.
 */
`include "timer3_ccp_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module timer3_ccp_mode_control (
	input  wire        i_clk,
	input  wire        i_srst,
	input  wire        i_ce,
	input  wire [3:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire        i_osc_clk,
	input  wire        i_ext_clk_pin,
	input  wire        i_capture_pin,
	input  wire        i_can_msg_rx,
	output reg  [7:0]  o_rdata,
	output reg         o_overflow_irq,
	output reg         o_unit_event_irq,
	output reg         o_special_trigger,
	output reg         o_adc_start,
	output reg         o_unit_pin,
	output reg         o_unit_pin_oe,
	output reg         o_pwm_mode,
	output reg  [9:0]  o_duty_cycle
);

	////////////////////////////////////////////////////////////////////////
	// registers
	reg [15:0] timer_reg;
	reg [7:0]  high_buffer_reg;
	reg [7:0]  timer_control_reg;
	reg [5:0]  unit_control_reg;
	reg [15:0] unit_data_reg;
	reg [3:0]  aux_control_reg;
	reg        overflow_flag_reg;
	reg        unit_event_flag_reg;
	reg [1:0]  instr_div_reg;
	reg [2:0]  prescale_reg;
	reg [3:0]  capture_count_reg;
	reg        match_prev_reg;
	reg        special_pending_reg;
	reg [3:0]  mode_prev_reg;
	reg        pin_reg;
	reg [2:0]  osc_sync_reg;
	reg [2:0]  ext_sync_reg;
	reg [2:0]  cap_sync_reg;

	////////////////////////////////////////////////////////////////////////
	// decoded controls
	wire [3:0] mode          = unit_control_reg[`UC_MODE_HI:`UC_MODE_LO];
	wire       wide_access   = timer_control_reg[`TC_WIDE_ACCESS];
	wire       ext_select    = timer_control_reg[`TC_EXT_CLOCK_SELECT];
	wire       timer_on      = timer_control_reg[`TC_TIMER_ON];
	wire [1:0] prescale_sel  = timer_control_reg[`TC_PRESCALE_HI:`TC_PRESCALE_LO];
	wire       osc_enable    = aux_control_reg[`AUX_LOW_FREQ_OSC_EN];
	wire       can_select    = aux_control_reg[`AUX_CAN_STAMP_SELECT];
	wire       adc_enable    = aux_control_reg[`AUX_ADC_ENABLE];
	wire       is_capture    = (mode[3:2] == 2'b01);
	wire       is_pwm        = (mode[3:2] == 2'b11);
	wire       is_compare    = (mode == `MODE_CMP_TOGGLE) || (mode[3:2] == 2'b10);

	// register port strobes
	wire wr_low    = i_wr && (i_addr == `OFS_TIMER_COUNT_LOW);
	wire wr_high   = i_wr && (i_addr == `OFS_TIMER_COUNT_HIGH);
	wire rd_low    = i_rd && (i_addr == `OFS_TIMER_COUNT_LOW);
	wire wr_dlow   = i_wr && (i_addr == `OFS_UNIT_DATA_LOW);
	wire wr_dhigh  = i_wr && (i_addr == `OFS_UNIT_DATA_HIGH);
	wire wr_status = i_wr && (i_addr == `OFS_EVENT_STATUS);
	// a direct high write only exists without wide access
	wire timer_write = wr_low || (wr_high && !wide_access);

	////////////////////////////////////////////////////////////////////////
	// edge detection on synchronised pins; stage 0 feeds only stage 1
	wire osc_rise = osc_sync_reg[1] && !osc_sync_reg[2];
	wire ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
	wire cap_rise = cap_sync_reg[1] && !cap_sync_reg[2];
	wire cap_fall = !cap_sync_reg[1] && cap_sync_reg[2];

	// clock source selection ahead of the prescaler
	wire instr_tick = (instr_div_reg == `INSTR_DIV_LAST);
	wire ext_tick   = osc_enable ? osc_rise : ext_rise;
	wire src_tick   = ext_select ? ext_tick : instr_tick;
	wire [2:0] prescale_mask = (3'h1 << prescale_sel) - 3'h1;
	wire count_tick = timer_on && src_tick && (prescale_reg == prescale_mask);

	// compare match: one pulse when the timer first equals the data pair
	wire match_now   = (timer_reg == unit_data_reg);
	wire match_pulse = is_compare && match_now && !match_prev_reg;

	// capture event source and prescaling
	wire cap_event_src = can_select ? i_can_msg_rx :
	                     ((mode == `MODE_CAP_FALL) ? cap_fall : cap_rise);
	reg  capture_fire;

	// capture edge divider selection
	always @* begin
		case (mode)
		`MODE_CAP_FALL,
		`MODE_CAP_RISE:   capture_fire = cap_event_src;
		`MODE_CAP_RISE4:  capture_fire = cap_event_src && (capture_count_reg[1:0] == 2'h3);
		`MODE_CAP_RISE16: capture_fire = cap_event_src && (capture_count_reg == 4'hf);
		default:          capture_fire = 1'b0;
		endcase
	end

	wire mode_changed = (mode != mode_prev_reg);

	////////////////////////////////////////////////////////////////////////
	// input synchronisers for the asynchronous pins; the third stage is only
	// the edge detectors' history, so a metastable first stage never reaches
	// the counting or capture logic
	always @(posedge i_clk) begin
		if (i_srst) begin
			osc_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
			cap_sync_reg <= 3'h0;
		end else if (i_ce) begin
			osc_sync_reg <= {osc_sync_reg[1:0], i_osc_clk};
			ext_sync_reg <= {ext_sync_reg[1:0], i_ext_clk_pin};
			cap_sync_reg <= {cap_sync_reg[1:0], i_capture_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers written by software
	always @(posedge i_clk) begin
		if (i_srst) begin
			timer_control_reg <= `RST_BYTE;
			unit_control_reg  <= 6'h00;
			aux_control_reg   <= 4'h0;
		end else if (i_ce && i_wr) begin
			case (i_addr)
			`OFS_TIMER_CONTROL: timer_control_reg <= i_wdata;
			`OFS_UNIT_CONTROL:  unit_control_reg  <= i_wdata[5:0];
			`OFS_AUX_CONTROL:   aux_control_reg   <= i_wdata[3:0];
			default:            aux_control_reg   <= aux_control_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// instruction clock divider and timer prescaler
	always @(posedge i_clk) begin
		if (i_srst) begin
			instr_div_reg <= 2'h0;
			prescale_reg  <= 3'h0;
		end else if (i_ce) begin
			instr_div_reg <= instr_div_reg + 2'h1;
			if (wr_low || !timer_on)
				prescale_reg <= 3'h0;                  // low write clears the prescaler
			else if (src_tick)
				prescale_reg <= (prescale_reg == prescale_mask) ? 3'h0 : prescale_reg + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 16-bit timer with wide access buffer and special-event reset; a software
	// write is tested first so that it beats a pending trigger reset, and the
	// reset beats a count tick, so a wrap that the reset replaces never reaches
	// the overflow logic
	always @(posedge i_clk) begin
		if (i_srst) begin
			timer_reg       <= `RST_WORD;
			high_buffer_reg <= `RST_BYTE;
		end else if (i_ce) begin
			if (rd_low && wide_access)
				high_buffer_reg <= timer_reg[15:8];
			else if (wr_high && wide_access)
				high_buffer_reg <= i_wdata;
			if (wr_low) begin
				timer_reg[7:0]  <= i_wdata;
				if (wide_access)
					timer_reg[15:8] <= high_buffer_reg;
			end else if (wr_high && !wide_access) begin
				timer_reg[15:8] <= i_wdata;
			end else if (special_pending_reg) begin
				timer_reg <= `RST_WORD;
			end else if (count_tick) begin
				timer_reg <= timer_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// special-event trigger pipeline and conversion start; the match is
	// registered once so that trigger, conversion start and timer reset all
	// leave flip-flops, which is why the timer clears one edge after the trigger
	always @(posedge i_clk) begin
		if (i_srst) begin
			special_pending_reg <= 1'b0;
			o_special_trigger   <= 1'b0;
			o_adc_start         <= 1'b0;
			match_prev_reg      <= 1'b0;
		end else if (i_ce) begin
			match_prev_reg <= match_now;
			// the trigger's timer reset is dropped when a timer write lands in the reset cycle
			special_pending_reg <= match_pulse && (mode == `MODE_CMP_SPECIAL);
			o_special_trigger   <= match_pulse && (mode == `MODE_CMP_SPECIAL);
			o_adc_start <= match_pulse && (mode == `MODE_CMP_SPECIAL) && adc_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky flags; a set in the clearing cycle wins, so software that clears
	// a flag just as a new event arrives still sees that event afterwards
	// rather than losing it silently
	always @(posedge i_clk) begin
		if (i_srst) begin
			overflow_flag_reg   <= 1'b0;
			unit_event_flag_reg <= 1'b0;
		end else if (i_ce) begin
			// only a counting wrap sets the flag, never the trigger reset
			if (count_tick && !timer_write && !special_pending_reg &&
			    timer_reg == `TIMER_MAX)
				overflow_flag_reg <= 1'b1;
			else if (wr_status && i_wdata[`ST_OVERFLOW_FLAG])
				overflow_flag_reg <= 1'b0;
			if (match_pulse || capture_fire)
				unit_event_flag_reg <= 1'b1;
			else if (wr_status && i_wdata[`ST_UNIT_EVENT_FLAG])
				unit_event_flag_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// unit data register: software access and captures
	always @(posedge i_clk) begin
		if (i_srst) begin
			unit_data_reg <= `RST_WORD;
		end else if (i_ce) begin
			if (capture_fire)
				unit_data_reg <= timer_reg;
			else if (wr_dlow)
				unit_data_reg[7:0] <= i_wdata;
			else if (wr_dhigh)
				unit_data_reg[15:8] <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// capture prescaler, cleared whenever capture is not selected; switching
	// between capture modes keeps the count, so the first capture may come early
	always @(posedge i_clk) begin
		if (i_srst) begin
			capture_count_reg <= 4'h0;
		end else if (i_ce) begin
			if (!is_capture || mode == `MODE_OFF)
				capture_count_reg <= 4'h0;
			else if (cap_event_src)
				capture_count_reg <= capture_count_reg + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare output pin state; the start level of the set and clear modes is
	// loaded on the cycle after the mode is written, and rewriting the same
	// mode does not load it again; reserved codes leave the pin alone
	always @(posedge i_clk) begin
		if (i_srst) begin
			pin_reg       <= 1'b0;
			mode_prev_reg <= `MODE_OFF;
		end else if (i_ce) begin
			mode_prev_reg <= mode;
			case (mode)
			`MODE_OFF: begin
				pin_reg <= 1'b0;
			end
			`MODE_CMP_TOGGLE: begin
				if (match_pulse)
					pin_reg <= !pin_reg;
			end
			`MODE_CMP_SET_HIGH: begin
				if (mode_changed)
					pin_reg <= 1'b0;
				else if (match_pulse)
					pin_reg <= 1'b1;
			end
			`MODE_CMP_SET_LOW: begin
				if (mode_changed)
					pin_reg <= 1'b1;
				else if (match_pulse)
					pin_reg <= 1'b0;
			end
			default: begin
				pin_reg <= pin_reg;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs, each one cycle behind the state it copies so that
	// no output of the block comes from combinational logic
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_overflow_irq   <= 1'b0;
			o_unit_event_irq <= 1'b0;
			o_unit_pin       <= 1'b0;
			o_unit_pin_oe    <= 1'b0;
			o_pwm_mode       <= 1'b0;
			o_duty_cycle     <= 10'h000;
		end else if (i_ce) begin
			o_overflow_irq   <= overflow_flag_reg && aux_control_reg[`AUX_OVERFLOW_IRQ_EN];
			o_unit_event_irq <= unit_event_flag_reg;
			o_unit_pin       <= pin_reg;
			// the unit drives the pin only in the pin-owning compare modes
			o_unit_pin_oe    <= (mode == `MODE_CMP_TOGGLE) || (mode == `MODE_CMP_SET_HIGH) ||
			                    (mode == `MODE_CMP_SET_LOW);
			o_pwm_mode       <= is_pwm;
			if (is_pwm)
				o_duty_cycle <= {unit_data_reg[7:0],
				                 unit_control_reg[`UC_DUTY_HI:`UC_DUTY_LO]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data stand in the cycle after the strobe only; the bus reads
	// zero otherwise so that several slaves may be ored together
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= `RST_BYTE;
		end else if (i_ce) begin
			if (i_rd) begin
				case (i_addr)
				`OFS_TIMER_COUNT_LOW:  o_rdata <= timer_reg[7:0];
				`OFS_TIMER_COUNT_HIGH: o_rdata <= wide_access ? high_buffer_reg :
				                                  timer_reg[15:8];
				`OFS_TIMER_CONTROL:    o_rdata <= timer_control_reg;
				`OFS_UNIT_CONTROL:     o_rdata <= {2'b00, unit_control_reg};
				`OFS_UNIT_DATA_LOW:    o_rdata <= unit_data_reg[7:0];
				`OFS_UNIT_DATA_HIGH:   o_rdata <= unit_data_reg[15:8];
				`OFS_AUX_CONTROL:      o_rdata <= {4'h0, aux_control_reg};
				`OFS_EVENT_STATUS:     o_rdata <= {6'h00, unit_event_flag_reg,
				                                   overflow_flag_reg};
				default:               o_rdata <= `RST_BYTE;
				endcase
			end else begin
				o_rdata <= `RST_BYTE;
			end
		end
	end

endmodule

// File: testbench/timer3_ccp_monitor.sv
/*
 * checker of the time base and unit mode control, seen from the top ports.
 * assumes i_ce held high and every register written over the byte port.
 */
`include "timer3_ccp_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module timer3_ccp_monitor (
	input  wire       i_clk,
	input  wire       i_srst,
	input  wire       i_ce,
	input  wire [3:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	input  wire [7:0] o_rdata,
	input  wire       o_overflow_irq,
	input  wire       o_unit_event_irq,
	input  wire       o_special_trigger,
	input  wire       o_adc_start,
	input  wire       o_unit_pin,
	input  wire       o_unit_pin_oe,
	input  wire       o_pwm_mode,
	input  wire [9:0] o_duty_cycle
);
	timeunit 1ns;
	timeprecision 100ps;
	reg [7:0] aux_reg;

	// shadow of aux_control, followed from port writes
	always @(posedge i_clk) begin
		if (i_srst) begin
			aux_reg <= 8'h00;
		end else if (i_ce && i_wr && i_addr == `OFS_AUX_CONTROL) begin
			aux_reg <= i_wdata;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// a write of one mode code into unit_control
	sequence uc_wr(m);
		i_wr && i_addr == `OFS_UNIT_CONTROL && i_wdata[3:0] == m;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	unit_ctl_read_a: assert property (i_rd && i_addr == `OFS_UNIT_CONTROL
		|=> o_rdata[7:6] == 2'b00) else $error("unit control top bits not zero");
	unmapped_read_a: assert property (i_rd && i_addr[3] |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	adc_with_trig_a: assert property (o_adc_start |-> o_special_trigger)
		else $error("conversion start without trigger");
	adc_gate_a: assert property (!aux_reg[3] && !$past(aux_reg[3]) |-> !o_adc_start)
		else $error("conversion start while converter off");
	trig_pulse_a: assert property (o_special_trigger |=> !o_special_trigger)
		else $error("trigger longer than one cycle");
	trig_flag_a: assert property (o_special_trigger |=> o_unit_event_irq)
		else $error("trigger without event flag");
	pwm_duty_a: assert property (i_wr && i_addr == `OFS_UNIT_CONTROL && i_wdata[3:2] == 2'b11
		|-> ##2 o_pwm_mode && o_duty_cycle[1:0] == $past(i_wdata[5:4], 2))
		else $error("pwm duty low bits wrong");
	mode_off_a: assert property (uc_wr(`MODE_OFF)
		|-> ##2 !o_pwm_mode && !o_unit_pin_oe ##1 !o_unit_pin) else $error("unit not cleared");
	pin_init_a: assert property (i_wr && i_addr == `OFS_UNIT_CONTROL && i_wdata[3:1] == 3'b100
		|-> ##2 o_unit_pin_oe ##1 o_unit_pin == $past(i_wdata[0], 3))
		else $error("pin start level wrong");
	soft_port_a: assert property (uc_wr(`MODE_CMP_SOFT) |-> ##2 !o_unit_pin_oe)
		else $error("pin driven in soft compare");
	ovf_gate_a: assert property (!aux_reg[1] && !$past(aux_reg[1]) |-> !o_overflow_irq)
		else $error("overflow request while disabled");
endmodule

// File: testbench/event_pin_model.sv
/*
 * far side of the unit: the capture event pin and the compare output pin.
 * assumes the port holds the compare pin low while the unit does not drive it.
 */

////////////////////////////////////////////////////////////////////////////////
module event_pin_model (
	input  wire i_clk,
	input  wire i_unit_pin,
	input  wire i_unit_pin_oe,
	output reg  o_capture_pin,
	output wire o_pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// pin level follows the unit only while it drives the pin
	assign o_pin_level = i_unit_pin_oe ? i_unit_pin : 1'b0;

	initial o_capture_pin = 1'b0;

	// one event: high then low, each held long enough for the synchroniser
	task pulse(input int hold);
		@(posedge i_clk);
		o_capture_pin <= 1'b1;
		repeat (hold) @(posedge i_clk);
		o_capture_pin <= 1'b0;
		repeat (hold) @(posedge i_clk);
	endtask
endmodule

// File: testbench/tb_timer3_ccp_mode_control.sv
/*
 * self-checking bench of the time base and unit mode control.
 * assumes the design answers reads one cycle after the strobe.
 */
`include "timer3_ccp_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module tb_timer3_ccp_mode_control;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [3:0] mode; bit can; int n; logic oe, p0, p1;} row_t;
	reg        i_clk, i_srst, i_ce, i_wr, i_rd, i_osc_clk, i_ext_clk_pin, i_can_msg_rx;
	reg  [3:0] i_addr;
	reg  [7:0] i_wdata, d, d2;
	reg        seen;
	wire [7:0] o_rdata;
	wire [9:0] o_duty_cycle;
	wire       o_overflow_irq, o_unit_event_irq, o_special_trigger, o_adc_start;
	wire       o_unit_pin, o_unit_pin_oe, o_pwm_mode, i_capture_pin, pin_level;
	int        errors, comparisons, n, k;
	row_t      rows[8] = '{'{4'h2, 0, 0, 1, 0, 1}, '{4'h8, 0, 0, 1, 0, 1},
		'{4'h9, 0, 0, 1, 1, 0}, '{4'ha, 0, 0, 0, 0, 0}, '{4'h4, 0, 1, 0, 0, 0},
		'{4'h5, 0, 1, 0, 0, 0}, '{4'h6, 0, 4, 0, 0, 0}, '{4'h7, 1, 16, 0, 0, 0}};

	timer3_ccp_mode_control i_timer3_ccp_mode_control (.i_clk(i_clk), .i_srst(i_srst),
		.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_osc_clk(i_osc_clk), .i_ext_clk_pin(i_ext_clk_pin), .i_capture_pin(i_capture_pin),
		.i_can_msg_rx(i_can_msg_rx), .o_rdata(o_rdata), .o_overflow_irq(o_overflow_irq),
		.o_unit_event_irq(o_unit_event_irq), .o_special_trigger(o_special_trigger),
		.o_adc_start(o_adc_start), .o_unit_pin(o_unit_pin), .o_unit_pin_oe(o_unit_pin_oe),
		.o_pwm_mode(o_pwm_mode), .o_duty_cycle(o_duty_cycle));
	event_pin_model i_event_pin_model (.i_clk(i_clk), .i_unit_pin(o_unit_pin),
		.i_unit_pin_oe(o_unit_pin_oe), .o_capture_pin(i_capture_pin), .o_pin_level(pin_level));

	// 250 MHz system clock
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle register write and read
	task wr(input [3:0] a, input [7:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task rd(input [3:0] a, output [7:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		v = o_rdata;
	endtask

	// bounded wait: 0 unit event, 1 special trigger, 2 overflow request
	task wait_sig(input int which, input int lim);
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
			seen = (which == 0) ? o_unit_event_irq : (which == 1) ? o_special_trigger
				: o_overflow_irq;
		end while (seen !== 1'b1 && n < lim);
		if (seen !== 1'b1) begin
			errors++;
			end_of_test;
		end
	endtask

	// one capture event, from the pin or as a received message
	task ev(input bit can);
		if (can) begin
			@(posedge i_clk);
			i_can_msg_rx <= 1'b1;
			@(posedge i_clk);
			i_can_msg_rx <= 1'b0;
			repeat (3) @(posedge i_clk);
		end else i_event_pin_model.pulse(6);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{i_srst, i_wr, i_rd, i_osc_clk, i_ext_clk_pin, i_can_msg_rx} = 6'h20;
		i_ce = 1'b1;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		errors = 0;
		comparisons = 0;
		repeat (6) @(posedge i_clk);
		i_srst <= 1'b0;
		for (k = 0; k < 9; k++) begin
			rd(k[3:0], d);
			chk(d, 8'h00);
		end
		wr(`OFS_TIMER_CONTROL, 8'h01);
		rd(`OFS_TIMER_COUNT_LOW, d);
		repeat (38) @(posedge i_clk);
		rd(`OFS_TIMER_COUNT_LOW, d2);
		chk(d2 - d, 8'h0a);
		wr(`OFS_UNIT_DATA_LOW, 8'h04);
		wr(`OFS_UNIT_DATA_HIGH, 8'h00);
		foreach (rows[i]) begin
			wr(`OFS_UNIT_CONTROL, 8'h00);
			wr(`OFS_AUX_CONTROL, {5'h00, rows[i].can, 2'b00});
			wr(`OFS_EVENT_STATUS, 8'h03);
			wr(`OFS_TIMER_COUNT_HIGH, 8'h00);
			wr(`OFS_TIMER_COUNT_LOW, 8'h00);
			wr(`OFS_UNIT_CONTROL, {4'h0, rows[i].mode});
			repeat (3) @(negedge i_clk);
			if (rows[i].mode[3] || rows[i].mode == `MODE_CMP_TOGGLE) begin
				chk(pin_level, rows[i].p0);
			end else begin
				if (rows[i].can) repeat (2) ev(1'b0);
				for (k = 1; k < rows[i].n; k++) ev(rows[i].can);
				chk(o_unit_event_irq, 1'b0);
				ev(rows[i].can);
			end
			wait_sig(0, 200);
			chk(o_unit_pin_oe, rows[i].oe);
			if (rows[i].oe) chk(pin_level, rows[i].p1);
		end
		wr(`OFS_UNIT_DATA_LOW, 8'h04);
		wr(`OFS_UNIT_CONTROL, 8'hff);
		rd(`OFS_UNIT_CONTROL, d);
		chk(d, 8'h3f);
		chk({o_pwm_mode, o_duty_cycle}, {1'b1, 8'h04, 2'b11});
		wr(`OFS_UNIT_DATA_HIGH, 8'h5a);
		rd(`OFS_UNIT_DATA_HIGH, d);
		chk(d, 8'h5a);
		wr(`OFS_UNIT_CONTROL, 8'h00);
		wr(`OFS_AUX_CONTROL, 8'h02);
		wr(`OFS_EVENT_STATUS, 8'h03);
		wr(`OFS_TIMER_COUNT_HIGH, 8'hff);
		wr(`OFS_TIMER_COUNT_LOW, 8'hf0);
		wait_sig(2, 200);
		rd(`OFS_TIMER_COUNT_HIGH, d);
		chk(d, 8'h00);
		wr(`OFS_AUX_CONTROL, 8'h08);
		wr(`OFS_EVENT_STATUS, 8'h03);
		wr(`OFS_UNIT_DATA_LOW, 8'h08);
		wr(`OFS_UNIT_DATA_HIGH, 8'h00);
		wr(`OFS_TIMER_COUNT_LOW, 8'h00);
		wr(`OFS_UNIT_CONTROL, {4'h0, `MODE_CMP_SPECIAL});
		wait_sig(1, 200);
		chk(o_adc_start, 1'b1);
		wait_sig(1, 100);
		chk(n >= 32 && n <= 36, 1'b1);
		rd(`OFS_TIMER_COUNT_LOW, d);
		chk(d, 8'h00);
		rd(`OFS_EVENT_STATUS, d);
		chk(d[1:0], 2'b10);
		wr(`OFS_AUX_CONTROL, 8'h01);
		wait_sig(1, 100);
		chk(o_adc_start, 1'b0);
		repeat (31) @(posedge i_clk);
		wr(`OFS_TIMER_COUNT_LOW, 8'h55);
		rd(`OFS_TIMER_COUNT_LOW, d);
		chk(d, 8'h55);
		wr(`OFS_UNIT_CONTROL, 8'h01);
		wr(`OFS_EVENT_STATUS, 8'h03);
		wr(`OFS_UNIT_DATA_LOW, 8'h03);
		wr(`OFS_TIMER_CONTROL, 8'h03);
		wr(`OFS_TIMER_COUNT_LOW, 8'h00);
		repeat (5) begin
			repeat (8) @(posedge i_clk);
			i_osc_clk <= 1'b1;
			repeat (8) @(posedge i_clk);
			i_osc_clk <= 1'b0;
		end
		rd(`OFS_TIMER_COUNT_LOW, d);
		chk(d, 8'h05);
		chk(o_unit_event_irq, 1'b0);
		wr(`OFS_AUX_CONTROL, 8'h00);
		repeat (3) begin
			repeat (8) @(posedge i_clk);
			i_ext_clk_pin <= 1'b1;
			repeat (8) @(posedge i_clk);
			i_ext_clk_pin <= 1'b0;
		end
		rd(`OFS_TIMER_COUNT_LOW, d);
		chk(d, 8'h08);
		wr(`OFS_TIMER_CONTROL, 8'h80);
		wr(`OFS_TIMER_COUNT_HIGH, 8'h12);
		wr(`OFS_TIMER_COUNT_LOW, 8'h34);
		wr(`OFS_TIMER_COUNT_HIGH, 8'h77);
		rd(`OFS_TIMER_COUNT_LOW, d);
		chk(d, 8'h34);
		rd(`OFS_TIMER_COUNT_HIGH, d);
		chk(d, 8'h12);
		end_of_test;
	end
endmodule

bind timer3_ccp_mode_control timer3_ccp_monitor i_timer3_ccp_monitor (.i_clk(i_clk),
	.i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_overflow_irq(o_overflow_irq),
	.o_unit_event_irq(o_unit_event_irq), .o_special_trigger(o_special_trigger),
	.o_adc_start(o_adc_start), .o_unit_pin(o_unit_pin), .o_unit_pin_oe(o_unit_pin_oe),
	.o_pwm_mode(o_pwm_mode), .o_duty_cycle(o_duty_cycle));
